// *** tmrc_pkg.sv ***
// Package for the track monitor and routing control block
package tmrc_pkg;
    localparam int TRACKS = 8;
    localparam int SW = 24;
    // Clock and timing
    localparam int CLK_HZ = 10_000_000;
    localparam int CONF_TIMEOUT_S = 5;
    localparam int CONF_TIMEOUT_CYC = CONF_TIMEOUT_S * CLK_HZ;
    localparam int CONF_DELAY_MS = 240;
    // Shuttle attenuation: 12 dB, two bits of right shift
    localparam int SHTL_ATTEN_DB = 12;
    localparam int SHTL_SHIFT = SHTL_ATTEN_DB / 6;
    localparam logic [6:0] LEVEL_MAX = 7'h7f;
    // Register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_KEYS = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_PATCH = 8'h0c;
    localparam logic [7:0] REG_FSCLS = 8'h10;
    localparam logic [7:0] REG_MASTER = 8'h14;
    localparam logic [7:0] REG_CHMIX = 8'h20;
    // Control field positions
    localparam int CTRL_ALLIN = 0;
    localparam int CTRL_AUTOMON = 1;
    localparam int CTRL_SHTLMON = 2;
    localparam int CTRL_SHTLMUTE = 3;
    localparam int CTRL_OUTSEL = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [23:0] PATCH_RESET = 24'hfac688;
    localparam logic [15:0] FSCLS_RESET = 16'h0000;
    // Key field positions
    localparam int KEY_ARM = 0;
    localparam int KEY_INMON = 8;
    localparam int KEY_CONF = 16;
    localparam int KEY_MIX = 17;
    typedef enum logic [1:0] {
        TMRC_FS_BASE = 2'b00,
        TMRC_FS_DUAL = 2'b01,
        TMRC_FS_QUAD = 2'b10
    } tmrc_fs_t;
    typedef enum logic [2:0] {
        TMRC_TR_STOP = 3'b000,
        TMRC_TR_PLAY = 3'b001,
        TMRC_TR_REC = 3'b010,
        TMRC_TR_SHTL = 3'b011
    } tmrc_tr_t;
    typedef enum logic [1:0] {
        TMRC_CF_OFF = 2'b00,
        TMRC_CF_ARMED = 2'b01,
        TMRC_CF_ON = 2'b10
    } tmrc_cf_t;
    typedef struct packed {
        logic [TRACKS-1:0][SW-1:0] smp;
        logic valid;
    } tmrc_frame_t;
    typedef struct packed {
        logic [6:0] level;
        logic [6:0] pan;
    } tmrc_chmix_t;
endpackage

// *** tmrc_delay_mem.sv ***
// Single-port style circular delay memory for off-tape confidence delay
`timescale 1ns/1ns
`default_nettype none
module tmrc_delay_mem
    import tmrc_pkg::*;
#(
    parameter int WIDTH = 192,
    parameter int DEPTH = 64
) (
    // Clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             nrst_in,
    // Sample stream
    input  wire logic             push_in,
    input  wire logic [WIDTH-1:0] wdata_in,
    output logic [WIDTH-1:0]      rdata_out
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2) $error("depth too small");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    ptr_q;
    logic [WIDTH-1:0] rdata_q;
    // Read before write gives exactly DEPTH samples of delay
    always_ff @(posedge core_clk_in) begin
        if (push_in) begin
            mem[ptr_q] <= wdata_in;
            rdata_q <= mem[ptr_q];
        end
    end
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ptr_q <= '0;
        end else if (push_in) begin
            ptr_q <= (ptr_q == AW'(DEPTH - 1)) ? '0 : ptr_q + 1'b1;
        end
    end
    assign rdata_out = rdata_q;
endmodule
`default_nettype wire

// *** tmrc_core.sv ***
// Track monitor source, output patch, confidence and mixdown control
// Overview of operation
// R1 - All-input override forces source during shuttle
// R2 - Auto-mon off: shuttle setting ignored, switch toggles
// R3 - Auto and shuttle on: armed tracks hear source
// R4 - Auto on, shuttle off: armed tracks hear tape
// R5 - Unarmed track switch always toggles source/tape; code ignores the switch and forces source while all-input is on
// R6 - Shuttle monitoring attenuated by twelve dB
// R7 - Shuttle mute silences shuttle monitoring
// R8 - Each output carries its patched track
// R9 - Patch only within same frequency class
// R10 - Outputs mirrored on AES, multichannel, expansion; code drives AES or multichannel per OUTSEL, expansion always
// R11 - Patch indicator lit when not identity
// R12 - Confidence recording: tape unless input switch
// R13 - Off-tape path delayed about 240 ms; code delays by DELAY_DEPTH samples, 64 by default
// R14 - Confidence pairs base tracks for arming
// R15 - Entering confidence clears all arming
// R16 - Either key of armed pair disarms both
// R17 - Outside confidence, arming is per track
// R18 - Double press within five seconds enters
// R19 - Single press leaves confidence mode
// R20 - Mixdown sums eight signals onto 7, 8
// R21 - Mixdown key toggles; outputs 1-6 silent
// R22 - Mixdown only with all base tracks
// R23 - Per-channel level, pan, master level
// R24 - Monitor sources recomputed every cycle
//
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module tmrc_core
    import tmrc_pkg::*;
#(
    parameter int CONF_TIMEOUT = CONF_TIMEOUT_CYC,
    parameter int DELAY_DEPTH = 64
) (
    // Clock and reset
    input  wire logic                core_clk_in,
    input  wire logic                nrst_in,
    // Wishbone slave
    input  wire logic                wb_cyc_in,
    input  wire logic                wb_stb_in,
    input  wire logic                wb_we_in,
    input  wire logic [7:0]          wb_adr_in,
    input  wire logic [3:0]          wb_sel_in,
    input  wire logic [31:0]         wb_dat_in,
    output logic [31:0]              wb_dat_out,
    output logic                     wb_ack_out,
    // Transport and audio in
    input  wire tmrc_tr_t            transport_in,
    input  wire tmrc_frame_t         src_in,
    input  wire tmrc_frame_t         tape_in,
    // Audio out and indicators
    output tmrc_frame_t              aes_out,
    output tmrc_frame_t              mch_out,
    output tmrc_frame_t              slot_out,
    output logic [TRACKS-1:0]        armed_out,
    output logic [TRACKS-1:0]        inmon_lamp_out,
    output logic                     patch_lamp_out,
    output logic                     conf_lamp_out,
    output logic                     mix_lamp_out
);
    initial begin
        if (CONF_TIMEOUT < 2 || CONF_TIMEOUT > 2**26) $error("timeout out of counter range");
    end

    typedef struct packed {
        logic [31:0]             ctrl;
        logic [7:0][2:0]         patch;
        logic [7:0][1:0]         fscls;
        logic [6:0]              master;
        logic [7:0][13:0]        chmix;
        logic [TRACKS-1:0]       arm;
        logic [TRACKS-1:0]       inmon;
        tmrc_cf_t                cf;
        logic [25:0]             cf_cnt;
        logic                    mix;
        logic                    ack;
        logic [31:0]             rdat;
        tmrc_frame_t             out;
        logic                    err;
    } tmrc_state_t;

    tmrc_state_t s_q;
    tmrc_state_t s_d;
    tmrc_frame_t tape_dly;
    logic [191:0] dly_raw;

    // Circular delay stands in for the tape path latency
    tmrc_delay_mem #(
        .WIDTH (192),
        .DEPTH (DELAY_DEPTH)
    ) u_dly (
        .core_clk_in (core_clk_in),
        .nrst_in     (nrst_in),
        .push_in     (src_in.valid),
        .wdata_in    (src_in.smp),
        .rdata_out   (dly_raw)
    ); // R13

    assign tape_dly = {dly_raw, src_in.valid};

    function automatic logic fs_ok(input logic [7:0][1:0] f, input logic [2:0] trk, input logic [2:0] ch);
        fs_ok = (f[trk] == f[ch]);
    endfunction

    function automatic logic [SW-1:0] att(input logic [SW-1:0] v);
        att = SW'($signed(v) >>> SHTL_SHIFT);
    endfunction

    logic               wr;
    logic               rd;
    logic [TRACKS-1:0]  arm_key;
    logic [TRACKS-1:0]  inm_key;
    logic               conf_key;
    logic               mix_key;
    logic [TRACKS-1:0]  use_src;
    logic [TRACKS-1:0][SW-1:0] mon;
    logic               shtl;
    logic               all_base;
    logic               not_norm;
    logic signed [40:0] acc_l;
    logic signed [40:0] acc_r;
    logic signed [40:0] prod;
    logic [7:0]         pan_r;
    logic [7:0]         pan_l;
    logic [2:0]         pt;
    logic [TRACKS-1:0]  pair;

    always_comb begin
        s_d = s_q;
        wr = wb_cyc_in && wb_stb_in && wb_we_in && !s_q.ack;
        rd = wb_cyc_in && wb_stb_in && !s_q.ack;
        arm_key = '0;
        inm_key = '0;
        conf_key = 1'b0;
        mix_key = 1'b0;
        s_d.ack = rd;
        pt = '0;
        if (wr && wb_adr_in == REG_KEYS && wb_sel_in[0]) arm_key = wb_dat_in[KEY_ARM +: 8];
        if (wr && wb_adr_in == REG_KEYS && wb_sel_in[1]) inm_key = wb_dat_in[KEY_INMON +: 8];
        if (wr && wb_adr_in == REG_KEYS && wb_sel_in[2]) begin
            conf_key = wb_dat_in[KEY_CONF];
            mix_key = wb_dat_in[KEY_MIX];
        end
        if (wr && wb_adr_in == REG_CTRL && wb_sel_in[0]) s_d.ctrl[7:0] = wb_dat_in[7:0];
        if (wr && wb_adr_in == REG_FSCLS && wb_sel_in[1:0] == 2'b11) s_d.fscls = wb_dat_in[15:0];
        if (wr && wb_adr_in == REG_MASTER && wb_sel_in[0]) s_d.master = wb_dat_in[6:0]; // R23
        for (int c = 0; c < TRACKS; c++) begin
            if (wr && wb_adr_in == REG_CHMIX + 8'(4 * c) && wb_sel_in[1:0] == 2'b11) begin
                s_d.chmix[c] = {wb_dat_in[14:8], wb_dat_in[6:0]}; // R23
            end
        end
        // Patch write refused per channel when class differs
        s_d.err = s_q.err;
        if (wr && wb_adr_in == REG_PATCH && wb_sel_in[2:0] == 3'b111) begin
            s_d.err = 1'b0;
            for (int c = 0; c < TRACKS; c++) begin
                pt = wb_dat_in[3*c +: 3];
                if (fs_ok(s_q.fscls, pt, 3'(c))) s_d.patch[c] = pt; // R9
                else s_d.err = 1'b1;
            end
        end
        // Confidence key state machine
        s_d.cf_cnt = (s_q.cf == TMRC_CF_ARMED) ? s_q.cf_cnt + 1'b1 : '0;
        unique case (s_q.cf)
            TMRC_CF_OFF: begin
                if (conf_key) s_d.cf = TMRC_CF_ARMED; // R18
            end
            TMRC_CF_ARMED: begin
                if (conf_key) begin
                    s_d.cf = TMRC_CF_ON; // R18
                    s_d.arm = '0; // R15
                end else if (s_q.cf_cnt >= 26'(CONF_TIMEOUT - 1)) begin
                    s_d.cf = TMRC_CF_OFF; // R18
                end
            end
            TMRC_CF_ON: begin
                if (conf_key) s_d.cf = TMRC_CF_OFF; // R19
            end
            default: s_d.cf = TMRC_CF_OFF;
        endcase
        // Arming: paired in confidence for base tracks
        if (s_q.cf == TMRC_CF_ON) begin
            for (int t = 0; t < TRACKS; t += 2) begin
                pair[t] = s_q.fscls[t] == TMRC_FS_BASE && s_q.fscls[t+1] == TMRC_FS_BASE;
                pair[t+1] = pair[t];
                if (pair[t] && (arm_key[t] || arm_key[t+1])) begin
                    s_d.arm[t] = !(s_q.arm[t] || s_q.arm[t+1]); // R14 R16
                    s_d.arm[t+1] = s_d.arm[t];
                end else begin
                    s_d.arm[t] = s_q.arm[t] ^ arm_key[t];
                    s_d.arm[t+1] = s_q.arm[t+1] ^ arm_key[t+1];
                end
            end
        end else begin
            pair = '0;
            if (s_q.cf != TMRC_CF_ARMED || !conf_key) s_d.arm = s_q.arm ^ arm_key; // R17
        end
        // Input monitor switches locked while all-input is on
        if (!s_q.ctrl[CTRL_ALLIN]) s_d.inmon = s_q.inmon ^ inm_key;
        // Mixdown toggle, dropped if any track leaves base class
        all_base = 1'b1;
        for (int t = 0; t < TRACKS; t++) all_base &= (s_q.fscls[t] == TMRC_FS_BASE);
        if (mix_key && all_base) s_d.mix = !s_q.mix; // R21 R22
        if (!all_base) s_d.mix = 1'b0; // R22
        // Monitor source per track, recomputed each cycle
        shtl = transport_in == TMRC_TR_SHTL;
        for (int t = 0; t < TRACKS; t++) begin
            use_src[t] = s_q.inmon[t]; // R5 R24
            if (s_q.ctrl[CTRL_ALLIN]) begin
                use_src[t] = 1'b1; // R1
            end else if (shtl && s_q.arm[t] && s_q.ctrl[CTRL_AUTOMON]) begin
                use_src[t] = s_q.ctrl[CTRL_SHTLMON]; // R3 R4
            end else if (shtl) begin
                use_src[t] = s_q.inmon[t]; // R2
            end else if (s_q.cf == TMRC_CF_ON && transport_in == TMRC_TR_REC) begin
                use_src[t] = s_q.inmon[t]; // R12
            end else if (s_q.ctrl[CTRL_AUTOMON] && s_q.arm[t]) begin
                use_src[t] = transport_in != TMRC_TR_PLAY;
            end
            mon[t] = use_src[t] ? src_in.smp[t]
                   : (s_q.cf == TMRC_CF_ON ? tape_dly.smp[t] : tape_in.smp[t]);
            if (shtl) mon[t] = att(mon[t]); // R6
            if (shtl && s_q.ctrl[CTRL_SHTLMUTE]) mon[t] = '0; // R7
        end
        // Patch and mixdown into output frame
        acc_l = '0;
        acc_r = '0;
        prod = '0;
        pan_r = '0;
        pan_l = '0;
        for (int t = 0; t < TRACKS; t++) begin
            pan_r = {1'b0, s_q.chmix[t][6:0]};
            pan_l = 8'(LEVEL_MAX) - pan_r;
            prod = 41'($signed(mon[t])) * 41'($signed({1'b0, s_q.chmix[t][13:7]}));
            acc_l = acc_l + 41'((prod * $signed({1'b0, pan_l})) >>> 7);
            acc_r = acc_r + 41'((prod * $signed({1'b0, pan_r})) >>> 7);
        end
        acc_l = 41'((acc_l * $signed({1'b0, s_q.master})) >>> 17); // R23
        acc_r = 41'((acc_r * $signed({1'b0, s_q.master})) >>> 17);
        s_d.out.valid = src_in.valid;
        for (int c = 0; c < TRACKS; c++) begin
            s_d.out.smp[c] = mon[s_q.patch[c]]; // R8
        end
        if (s_q.mix) begin
            for (int c = 0; c < 6; c++) s_d.out.smp[c] = '0; // R21
            s_d.out.smp[6] = acc_l[SW-1:0]; // R20
            s_d.out.smp[7] = acc_r[SW-1:0]; // R20
        end
        // Indicator for non-identity patch
        not_norm = 1'b0;
        for (int c = 0; c < TRACKS; c++) not_norm |= (s_q.patch[c] != 3'(c)); // R11
        // Register reads
        if (rd && !wb_we_in) begin
            // Read data holds until the next read
            s_d.rdat = '0;
            unique case (wb_adr_in)
                REG_CTRL:   s_d.rdat = s_q.ctrl;
                REG_STATUS: s_d.rdat = {11'h0, s_q.err, not_norm, s_q.mix, s_q.cf, s_q.inmon, s_q.arm};
                REG_PATCH:  s_d.rdat = {8'h0, s_q.patch};
                REG_FSCLS:  s_d.rdat = {16'h0, s_q.fscls};
                REG_MASTER: s_d.rdat = {25'h0, s_q.master};
                default: begin
                    for (int c = 0; c < TRACKS; c++) begin
                        if (wb_adr_in == REG_CHMIX + 8'(4 * c)) begin
                            s_d.rdat = {17'h0, s_q.chmix[c][13:7], 1'b0, s_q.chmix[c][6:0]};
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_q <= '0;
            s_q.ctrl <= CTRL_RESET;
            s_q.patch <= PATCH_RESET;
            s_q.fscls <= FSCLS_RESET;
            s_q.master <= LEVEL_MAX;
            s_q.chmix <= {8{LEVEL_MAX, 7'h40}};
            s_q.cf <= TMRC_CF_OFF;
        end else begin
            s_q <= s_d;
        end
    end

    // Same frame on expansion and on the port that selection picks; the other port is zero
    assign aes_out = s_q.ctrl[CTRL_OUTSEL] ? '0 : s_q.out; // R10
    assign mch_out = s_q.ctrl[CTRL_OUTSEL] ? s_q.out : '0; // R10
    assign slot_out = s_q.out; // R10
    assign wb_ack_out = s_q.ack;
    assign wb_dat_out = s_q.rdat;
    assign armed_out = s_q.arm;
    assign inmon_lamp_out = s_q.ctrl[CTRL_ALLIN] ? '1 : s_q.inmon;
    assign patch_lamp_out = (s_q.patch != PATCH_RESET); // R11
    assign conf_lamp_out = (s_q.cf == TMRC_CF_ON) || (s_q.cf == TMRC_CF_ARMED && s_q.cf_cnt[21]);
    assign mix_lamp_out = s_q.mix;
endmodule
`default_nettype wire

// *** tmrc_core_asserts.sv ***
// Assertion checker for the track monitor and routing block
`timescale 1ns/1ns
`default_nettype none
module tmrc_chk
    import tmrc_pkg::*;
#(
    parameter int CONF_TIMEOUT = CONF_TIMEOUT_CYC,
    parameter int DELAY_DEPTH  = 64
) (
    // Clock and reset
    input wire logic              core_clk_in,
    input wire logic              nrst_in,
    // Register bus
    input wire logic              wb_cyc_in,
    input wire logic              wb_stb_in,
    input wire logic              wb_we_in,
    input wire logic [7:0]        wb_adr_in,
    input wire logic [3:0]        wb_sel_in,
    input wire logic [31:0]       wb_dat_in,
    input wire logic [31:0]       wb_dat_out,
    input wire logic              wb_ack_out,
    // Audio and lamps
    input wire tmrc_tr_t          transport_in,
    input wire tmrc_frame_t       src_in,
    input wire tmrc_frame_t       tape_in,
    input wire tmrc_frame_t       aes_out,
    input wire tmrc_frame_t       mch_out,
    input wire tmrc_frame_t       slot_out,
    input wire logic [TRACKS-1:0] armed_out,
    input wire logic [TRACKS-1:0] inmon_lamp_out,
    input wire logic              patch_lamp_out,
    input wire logic              conf_lamp_out,
    input wire logic              mix_lamp_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    // Lamps may lag the write by one registered stage
    wire logic wr_ack = wb_ack_out && wb_we_in && wb_cyc_in;
    property p_ack_once; wb_ack_out |=> !wb_ack_out; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
    property p_ack_resp; wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out; endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("request not answered");
    property p_rd_hold; !$stable(wb_dat_out) |-> wb_ack_out; endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without ack");
    property p_mirror; slot_out == (aes_out | mch_out) && (aes_out == '0 || mch_out == '0); endproperty
    a_mirror: assert property (p_mirror) else $error("outputs not mirrored");
    property p_mix_quiet; mix_lamp_out && $past(mix_lamp_out) && $past(mix_lamp_out, 2) |-> slot_out.smp[5:0] == '0;
    endproperty
    a_mix_quiet: assert property (p_mix_quiet) else $error("outputs 1 to 6 active in mixdown");
    property p_patch_lamp; !$stable(patch_lamp_out) |-> wr_ack || $past(wr_ack); endproperty
    a_patch_lamp: assert property (p_patch_lamp) else $error("patch lamp moved alone");
    property p_mix_rose; $rose(mix_lamp_out) |-> wr_ack || $past(wr_ack); endproperty
    a_mix_rose: assert property (p_mix_rose) else $error("mixdown started alone");
    property p_arm_chg; !$stable(armed_out) |-> wr_ack || $past(wr_ack); endproperty
    a_arm_chg: assert property (p_arm_chg) else $error("arming moved alone");
    property p_inmon_chg; !$stable(inmon_lamp_out) |-> wr_ack || $past(wr_ack); endproperty
    a_inmon_chg: assert property (p_inmon_chg) else $error("input lamps moved alone");
endmodule
bind tmrc_core tmrc_chk #(.CONF_TIMEOUT(CONF_TIMEOUT), .DELAY_DEPTH(DELAY_DEPTH)) i_tmrc_chk (.*);
`default_nettype wire

// *** tmrc_mon_sink.sv ***
// Monitoring sink model on the digital audio outputs
`timescale 1ns/1ns
`default_nettype none
module tmrc_mon_sink
    import tmrc_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        nrst_in,
    // Audio in and capture
    input  wire tmrc_frame_t frame_in,
    output var tmrc_frame_t  cap_out
);
    // Holds the last valid frame, as a meter would
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cap_out <= '0;
        end else if (frame_in.valid) begin
            cap_out <= frame_in;
        end
    end
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the track monitor and routing block
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import tmrc_pkg::*;
;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, pl, cl, ml;
    logic [7:0]  adr = 8'h00, arm, inl;
    logic [31:0] wdat = 32'h0, rdat;
    tmrc_tr_t    tr = TMRC_TR_PLAY;
    tmrc_frame_t src = '0, tape = '0, aes, mch, slot, cap;
    logic [23:0] s [8], t [8], s_prev;
    int          err_total = 0, tests_run = 0;
    always #50 clk = ~clk;
    tmrc_core #(.CONF_TIMEOUT(20), .DELAY_DEPTH(8)) i_tmrc_core (
        .core_clk_in(clk), .nrst_in(nrst), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
        .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
        .transport_in(tr), .src_in(src), .tape_in(tape), .aes_out(aes), .mch_out(mch), .slot_out(slot),
        .armed_out(arm), .inmon_lamp_out(inl), .patch_lamp_out(pl), .conf_lamp_out(cl), .mix_lamp_out(ml));
    tmrc_mon_sink i_tmrc_mon_sink (.core_clk_in(clk), .nrst_in(nrst), .frame_in(aes), .cap_out(cap));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        if (err_total == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Waits for ack as long as it takes; the watchdog ends a hang
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
        wb(1'b0, a, 32'h0);
        chk(rdat & m, e);
    endtask
    task automatic key(input logic [31:0] d);
        wr(REG_KEYS, d);
    endtask
    task automatic hold;
        repeat (3) @(negedge clk);
    endtask
    function automatic logic [23:0] att(input logic [23:0] x);
        return x >> SHTL_SHIFT;
    endfunction
    task automatic smp(input int i, input logic [23:0] e);
        chk({8'h00, cap.smp[i]}, {8'h00, e});
    endtask
    task automatic frames;
        @(posedge clk);
        foreach (s[i]) begin
            s[i] = 24'($urandom) & 24'h3fffff;
            t[i] = 24'($urandom) & 24'h3fffff;
            src.smp[i] <= s[i];
            tape.smp[i] <= t[i];
        end
        src.valid <= 1'b1;
        tape.valid <= 1'b1;
    endtask
    initial begin
        void'($urandom(94561));
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        rd(REG_STATUS, 32'h0);
        rd(REG_PATCH, 32'hfac688);
        rd(REG_MASTER, 32'h7f);
        rd(REG_CHMIX, 32'h7f40);
        rd(8'hfc, 32'h0);
        for (int n = 0; n < 3; n++) begin
            frames();
            hold();
            for (int i = 0; i < 8; i++) smp(i, t[i]);
        end
        key(32'hff00);
        hold();
        for (int i = 0; i < 8; i++) smp(i, s[i]);
        key(32'hff00);
        wr(REG_CTRL, 32'h1);
        tr <= TMRC_TR_SHTL;
        hold();
        chk({24'h0, inl}, 32'hff);
        for (int i = 0; i < 8; i++) smp(i, att(s[i]));
        wr(REG_CTRL, 32'h6);
        key(32'h1);
        key(32'h100);
        hold();
        chk({24'h0, arm}, 32'h1);
        smp(0, att(s[0]));
        smp(1, att(t[1]));
        wr(REG_CTRL, 32'h2);
        hold();
        smp(0, att(t[0]));
        wr(REG_CTRL, 32'h0);
        hold();
        smp(0, att(s[0]));
        wr(REG_CTRL, 32'he);
        hold();
        chk({8'h0, aes.smp[1]}, 32'h0);
        // Override keeps the patch checks independent of arming
        wr(REG_CTRL, 32'h1);
        tr <= TMRC_TR_PLAY;
        wr(REG_PATCH, 32'hdac681);
        hold();
        chk({31'h0, pl}, 32'h1);
        smp(0, s[1]);
        smp(1, s[0]);
        smp(7, s[6]);
        wr(REG_PATCH, 32'hfac688);
        wr(REG_FSCLS, 32'h1);
        wr(REG_PATCH, 32'hfac680);
        hold();
        chk({31'h0, pl}, 32'h0);
        rd(REG_PATCH, 32'hfac688);
        key(32'h20000);
        hold();
        chk({31'h0, ml}, 32'h0);
        wr(REG_FSCLS, 32'h0);
        key(32'h20000);
        hold();
        chk({31'h0, ml}, 32'h1);
        chk({8'h0, aes.smp[2]}, 32'h0);
        key(32'h20000);
        wr(REG_CTRL, 32'h11);
        hold();
        chk({31'h0, |aes}, 32'h0);
        chk({31'h0, mch.valid}, 32'h1);
        wr(REG_CTRL, 32'h0);
        key(32'h10000);
        rd(REG_STATUS, 32'h10000, 32'h30000);
        repeat (30) @(posedge clk);
        rd(REG_STATUS, 32'h0, 32'h30000);
        key(32'h10000);
        key(32'h10000);
        hold();
        chk({31'h0, cl}, 32'h1);
        chk({24'h0, arm}, 32'h0);
        wr(REG_FSCLS, 32'h100);
        key(32'h8);
        chk({24'h0, arm}, 32'hc);
        key(32'h4);
        chk({24'h0, arm}, 32'h0);
        key(32'h10);
        key(32'h1);
        chk({24'h0, arm}, 32'h13);
        tr <= TMRC_TR_REC;
        s_prev = s[2];
        frames();
        hold();
        smp(2, s_prev);
        repeat (12) @(negedge clk);
        smp(2, s[2]);
        smp(0, s[0]);
        key(32'h10000);
        hold();
        chk({31'h0, cl}, 32'h0);
        key(32'h2);
        chk({24'h0, arm}, 32'h11);
        complete_run();
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        complete_run();
    end
endmodule
`default_nettype wire
